// File: hw/blpl_boot_loader.sv
// blpl_boot_loader: boot sequencer that fills program, x and y memory
// assumes sync reset; straps held steady during reset; scl also on link_clk
//
// Behaviour
// - boot store is a fixed read-only table of 512 words, 24 bits each.
// - boot routine starts whenever the core leaves reset.
// - two strap pins sampled during reset pick one of four modes.
// - both straps low: spi master loads program, x and y memory.
// - strap a low, b high: debug port enabled, wait, no loading.
// - strap a high: load over i2c, master if b low, slave if high.
// - each spi byte is eight bits out and eight in, clocked by sck.
// - spi transmit single buffered, receive double buffered.
// - as spi master the loader drives sck and the slave select.
// - i2c slave answers only its own address.
// - program memory 3072 words, x and y memory 1024 words each.
// - program memory written only through the move-instruction port.
`timescale 1ns/1ps
module blpl_boot_loader
  import blpl_pkg::*;
#(
  parameter logic [WORD_W-1:0] BOOT_ROM [ROM_WORDS] = '{default: '0},
  parameter logic [6:0]        OWN_ADDR = I2C_OWN_ADDR
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        i2c_link_clk,
  input  wire logic        boot_strap_pin_a,
  input  wire logic        boot_strap_pin_b,
  input  wire logic [8:0]  rom_addr,
  output logic [23:0]      rom_data,
  output logic             core_boot,
  output logic             app_run,
  output logic             debug_en,
  output logic             spi_sck,
  output logic             spi_ss_n,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  input  wire logic        i2c_scl_in,
  output logic             i2c_scl_out,
  output logic             i2c_scl_oe,
  input  wire logic        i2c_sda_in,
  output logic             i2c_sda_out,
  output logic             i2c_sda_oe,
  output logic             program_memory_move_we,
  output logic             x_data_memory_we,
  output logic             y_data_memory_we,
  output logic [11:0]      mem_addr,
  output logic [23:0]      mem_data
);

  typedef struct packed {
    logic [4:0]  sy1;
    logic [4:0]  sy2;
    logic        sda_d;
    logic [2:0]  tg;
    logic [1:0]  mode;
    blpl_top_t   top;
    logic        core_boot;
    logic        app_run;
    logic        debug_en;
    logic [23:0] rom_q;
    logic        bvld;
    logic [7:0]  bhold;
    logic [1:0]  region;
    logic [1:0]  bidx;
    logic [15:0] wsh;
    logic [11:0] widx;
    logic        pwe;
    logic        xwe;
    logic        ywe;
    logic [11:0] maddr;
    logic [23:0] mdata;
    logic [7:0]  div;
    logic [3:0]  bitc;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [1:0]  hdr;
    logic        sck;
    logic        ss_n;
    logic        mosi;
    blpl_im_t    im;
    logic [1:0]  q;
    logic        scl_oe;
    logic        sda_oe;
    logic        ilast;
    logic        slv_clr;
  } blpl_state_t;

  blpl_state_t st;
  blpl_state_t nxt;
  logic        s_a, s_b, s_miso, s_scl, s_sda;
  logic        slv_ack, slv_tgl;
  logic [7:0]  slv_byte;
  logic [11:0] rlast;
  logic        is_last;

  assign {s_a, s_b, s_miso, s_scl, s_sda} = st.sy2;
  assign rlast = (st.region == REGION_PROG) ? PROG_LAST :
                 (st.region == REGION_X) ? X_LAST : Y_LAST;
  assign is_last = (st.region == REGION_Y) && (st.widx == Y_LAST) &&
                   (st.bidx == 2'h2);

  // ---------------------------------------------------------------
  // i2c slave receiver, link clock domain
  // ---------------------------------------------------------------
  blpl_i2c_slave_rx #(.OWN_ADDR(OWN_ADDR)) u_srx (
    .link_clk (i2c_link_clk),
    .clr      (st.slv_clr),
    .sda_in   (i2c_sda_in),
    .ack      (slv_ack),
    .byte_q   (slv_byte),
    .tgl      (slv_tgl)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt = st;
    nxt.bvld = 1'b0;
    nxt.pwe  = 1'b0;
    nxt.xwe  = 1'b0;
    nxt.ywe  = 1'b0;
    if (rst) begin
      nxt           = '0;
      nxt.mode      = {s_a, s_b};
      nxt.core_boot = 1'b1;
      nxt.ss_n      = 1'b1;
      nxt.slv_clr   = 1'b1;
    end else begin
      case (st.top)
        T_IDLE: begin
          nxt.top = T_LOAD;
          case (st.mode)
            MODE_SPI_M: begin
              nxt.ss_n = 1'b0;
              nxt.tx   = SPI_READ_CMD;
              nxt.mosi = SPI_READ_CMD[7];
              nxt.hdr  = SPI_HDR_BYTES;
            end
            MODE_DEBUG: begin
              nxt.top      = T_DEBUG;
              nxt.debug_en = 1'b1;
            end
            default: nxt.im = IM_START;
          endcase
        end
        T_LOAD, T_DONE: begin
          // spi master, mode 0; miso sampled just before the falling edge
          if (st.mode == MODE_SPI_M && st.top == T_LOAD) begin
            if (st.div == SPI_HALF_M1) begin
              nxt.div = 8'h00;
              if (!st.sck) nxt.sck = 1'b1;
              else begin
                nxt.sck  = 1'b0;
                nxt.rx   = {st.rx[6:0], s_miso};
                nxt.tx   = {st.tx[6:0], 1'b0};
                nxt.mosi = st.tx[6];
                nxt.bitc = st.bitc + 4'h1;
                if (st.bitc == 4'h7) begin
                  nxt.bitc = 4'h0;
                  nxt.tx   = 8'h00;
                  nxt.mosi = 1'b0;
                  if (st.hdr != 2'h0) nxt.hdr = st.hdr - 2'h1;
                  else begin
                    nxt.bvld  = 1'b1;
                    nxt.bhold = {st.rx[6:0], s_miso};
                  end
                end
              end
            end else nxt.div = st.div + 8'h01;
          end
          // i2c master: four quarters per bit, clock stretching ignored
          if (st.mode == MODE_I2C_M) begin
            if (st.div != I2C_QTR_M1) nxt.div = st.div + 8'h01;
            else begin
              nxt.div = 8'h00;
              nxt.q   = st.q + 2'h1;
              case (st.im)
                IM_START: begin
                  if (st.q == 2'h1) nxt.sda_oe = 1'b1;
                  if (st.q == 2'h3) begin
                    nxt.scl_oe = 1'b1;
                    nxt.im     = IM_ADDR;
                    nxt.tx     = {I2C_MEM_ADDR, 1'b1};
                    nxt.bitc   = 4'h0;
                  end
                end
                IM_ADDR, IM_READ: begin
                  case (st.q)
                    2'h0: nxt.sda_oe = st.bitc[3] ?
                            (st.im == IM_READ && !st.ilast) :
                            (st.im == IM_ADDR && !st.tx[7]);
                    2'h1: nxt.scl_oe = 1'b0;
                    2'h2: begin
                      if (!st.bitc[3]) nxt.rx = {st.rx[6:0], s_sda};
                      else if (st.im == IM_ADDR) nxt.ilast = s_sda;
                    end
                    default: begin
                      nxt.scl_oe = 1'b1;
                      nxt.tx     = {st.tx[6:0], 1'b0};
                      nxt.bitc   = st.bitc + 4'h1;
                      if (st.im == IM_READ && st.bitc == 4'h7) begin
                        nxt.bvld  = 1'b1;
                        nxt.bhold = st.rx;
                        nxt.ilast = is_last;
                      end
                      if (st.bitc[3]) begin
                        nxt.bitc = 4'h0;
                        if (st.ilast) nxt.im = IM_STOP;
                        else          nxt.im = IM_READ;
                        nxt.ilast = 1'b0;
                      end
                    end
                  endcase
                end
                IM_STOP: begin
                  case (st.q)
                    2'h0: nxt.sda_oe = 1'b1;
                    2'h1: nxt.scl_oe = 1'b0;
                    2'h3: begin
                      nxt.sda_oe = 1'b0;
                      // an address nack retries the read
                      nxt.im = (st.top == T_DONE) ? IM_END : IM_START;
                    end
                    default: ;
                  endcase
                end
                default: ;
              endcase
            end
          end
          // i2c slave: frame bounds found on oversampled pins
          if (st.mode == MODE_I2C_S) begin
            if (s_scl && (st.sda_d != s_sda)) nxt.slv_clr = 1'b1;
            else if (!s_scl)                  nxt.slv_clr = 1'b0;
            // a clear can flip the toggle, so bytes count only outside it
            if ((st.tg[2] ^ st.tg[1]) && !st.slv_clr) begin
              nxt.bvld  = 1'b1;
              nxt.bhold = slv_byte;
            end
          end
          // word assembly, most significant byte first
          if (st.top == T_LOAD && st.bvld) begin
            nxt.bidx = st.bidx + 2'h1;
            nxt.wsh  = {st.wsh[7:0], st.bhold};
            if (st.bidx == 2'h2) begin
              nxt.bidx  = 2'h0;
              nxt.mdata = {st.wsh, st.bhold};
              nxt.maddr = st.widx;
              nxt.pwe   = (st.region == REGION_PROG);
              nxt.xwe   = (st.region == REGION_X);
              nxt.ywe   = (st.region == REGION_Y);
              nxt.widx  = st.widx + 12'h001;
              if (st.widx == rlast) begin
                nxt.widx   = 12'h000;
                nxt.region = st.region + 2'h1;
                if (st.region == REGION_Y) begin
                  nxt.top       = T_DONE;
                  nxt.app_run   = 1'b1;
                  nxt.core_boot = 1'b0;
                  nxt.ss_n      = 1'b1;
                  nxt.sck       = 1'b0;
                  nxt.mosi      = 1'b0;
                end
              end
            end
          end
        end
        default: ;
      endcase
    end
    nxt.sy1   = {boot_strap_pin_a, boot_strap_pin_b, spi_miso,
                 i2c_scl_in, i2c_sda_in};
    nxt.sy2   = st.sy1;
    nxt.sda_d = s_sda;
    nxt.tg    = {st.tg[1:0], slv_tgl};
    nxt.rom_q = BOOT_ROM[rom_addr];
  end

  always_ff @(posedge clk) begin
    st <= nxt;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rom_data               = st.rom_q;
  assign core_boot              = st.core_boot;
  assign app_run                = st.app_run;
  assign debug_en               = st.debug_en;
  assign spi_sck                = st.sck;
  assign spi_ss_n               = st.ss_n;
  assign spi_mosi               = st.mosi;
  assign i2c_scl_out            = 1'b0;
  assign i2c_scl_oe             = st.scl_oe;
  assign i2c_sda_out            = 1'b0;
  assign i2c_sda_oe             = st.sda_oe | slv_ack;
  assign program_memory_move_we = st.pwe;
  assign x_data_memory_we       = st.xwe;
  assign y_data_memory_we       = st.ywe;
  assign mem_addr               = st.maddr;
  assign mem_data               = st.mdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [3:0] a_rises;
  logic       a_sck_d;
  always_ff @(posedge clk) begin
    a_sck_d <= st.sck;
    if (rst || (a_sck_d && !st.sck && st.bitc == 4'h0)) a_rises <= 4'h0;
    else if (!a_sck_d && st.sck) a_rises <= a_rises + 4'h1;
  end

  a_rom_read: assert property (
    1'b1 |=> st.rom_q == BOOT_ROM[$past(rom_addr)])
    else $error("boot store read wrong");
  a_boot_from_reset: assert property (
    $fell(rst) |-> st.core_boot && !st.app_run && st.top == T_IDLE)
    else $error("boot routine not entered after reset");
  a_strap_mode_catch: assert property (
    $fell(rst) |-> st.mode == $past(st.sy2[4:3]))
    else $error("strap levels not caught");
  a_spi_mode_only: assert property (
    !st.ss_n |-> st.mode == MODE_SPI_M && !st.app_run)
    else $error("spi select outside spi boot");
  a_debug_wait: assert property (
    (st.mode == MODE_DEBUG && st.top != T_IDLE) |->
      st.debug_en && !st.pwe && !st.xwe && !st.ywe && st.ss_n)
    else $error("debug mode not waiting");
  a_i2c_mode_only: assert property (
    (st.scl_oe || st.sda_oe) |-> st.mode == MODE_I2C_M)
    else $error("i2c master drive outside its mode");
  a_spi_eight_bits: assert property (
    (a_sck_d && !st.sck && st.bitc == 4'h0) |-> a_rises == 4'h8)
    else $error("spi byte not eight clocks");
  a_rx_hold_stable: assert property (
    (st.bvld && st.mode == MODE_SPI_M) |=> $stable(st.bhold) [*8])
    else $error("receive buffer overwritten early");
  a_spi_ss_load: assert property (
    (st.top == T_LOAD && st.mode == MODE_SPI_M) |-> !st.ss_n)
    else $error("slave select dropped during load");
  a_mem_depth: assert property (
    (st.pwe |-> st.maddr <= PROG_LAST) and
    ((st.xwe || st.ywe) |-> st.maddr <= X_LAST))
    else $error("memory write beyond depth");
  a_prog_via_move: assert property (
    st.pwe |-> $past(st.region) == REGION_PROG && !st.xwe && !st.ywe)
    else $error("program write outside move path");
  a_run_after_fill: assert property (
    $rose(st.app_run) |-> st.ywe && st.maddr == Y_LAST)
    else $error("application started before fill");

  c_spi_done: cover property (st.mode == MODE_SPI_M && $rose(st.app_run));
  c_i2cm_done: cover property (st.mode == MODE_I2C_M && $rose(st.app_run));
  c_i2cs_done: cover property (st.mode == MODE_I2C_S && $rose(st.app_run));
  c_debug: cover property ($rose(st.debug_en));

endmodule : blpl_boot_loader

// File: hw/blpl_i2c_slave_rx.sv
// blpl_i2c_slave_rx: byte receiver of the i2c slave boot mode
// assumes link_clk is the bus scl; clr is held high outside a frame
`timescale 1ns/1ps
module blpl_i2c_slave_rx
  import blpl_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = I2C_OWN_ADDR
) (
  input  wire logic       link_clk,
  input  wire logic       clr,
  input  wire logic       sda_in,
  output logic            ack,
  output logic [7:0]      byte_q,
  output logic            tgl
);

  typedef struct packed {
    logic [3:0] cnt;
    logic [6:0] sh;
    logic       first;
    logic       sel;
    logic       ack;
    logic       tgl;
    logic [7:0] dat;
  } blpl_srx_t;

  localparam blpl_srx_t SRX_RST = '{cnt: 4'h0, sh: 7'h00, first: 1'b1,
                                    sel: 1'b0, ack: 1'b0, tgl: 1'b0,
                                    dat: 8'h00};

  blpl_srx_t st;
  blpl_srx_t nxt;
  logic [7:0] nb;

  // ---------------------------------------------------------------
  // bit engine, falling scl edges
  // ---------------------------------------------------------------
  // data is stable across the falling edge, so sda needs no synchroniser
  always_comb begin
    nxt = st;
    nb  = {st.sh, sda_in};
    if (st.cnt == 4'h8) begin
      nxt.ack = 1'b0;
      nxt.cnt = 4'h0;
    end else begin
      nxt.sh  = nb[6:0];
      nxt.cnt = st.cnt + 4'h1;
      if (st.cnt == 4'h7) begin
        if (st.first) begin
          nxt.first = 1'b0;
          nxt.sel   = (nb[7:1] == OWN_ADDR) && !nb[0];
          nxt.ack   = (nb[7:1] == OWN_ADDR) && !nb[0];
        end else if (st.sel) begin
          nxt.dat = nb;
          nxt.tgl = ~st.tgl;
          nxt.ack = 1'b1;
        end
      end
    end
  end

  always_ff @(negedge link_clk or posedge clr) begin
    if (clr) st <= SRX_RST;
    else     st <= nxt;
  end

  assign ack    = st.ack;
  assign byte_q = st.dat;
  assign tgl    = st.tgl;

  a_slave_own_addr: assert property (@(negedge link_clk) disable iff (clr)
    $changed(st.tgl) |-> st.sel)
    else $error("byte passed on without own address");
  a_slave_ack_sel: assert property (@(negedge link_clk) disable iff (clr)
    (st.cnt == 4'h8 && st.ack && !st.first) |-> st.sel)
    else $error("ack given to a foreign address");

endmodule : blpl_i2c_slave_rx

// File: hw/blpl_pkg.sv
// blpl_pkg: constants and types of the boot-mode program loader
// assumes a 25 MHz core clock; memories take one word per core cycle
package blpl_pkg;

  // ---------------------------------------------------------------
  // clock and serial timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 40;
  localparam int SPI_SCK_MIN   = 12;    // least sck cycle, core clocks
  localparam int SPI_HALF_CYC  = SPI_SCK_MIN / 2;
  localparam int I2C_PERIOD_NS = 10000;
  localparam int I2C_QTR_CYC   = I2C_PERIOD_NS / (4 * CLK_NS);
  localparam logic [7:0] SPI_HALF_M1 = 8'(SPI_HALF_CYC - 1);
  localparam logic [7:0] I2C_QTR_M1  = 8'(I2C_QTR_CYC - 1);

  // ---------------------------------------------------------------
  // memories
  // ---------------------------------------------------------------
  localparam int WORD_W     = 24;
  localparam int ROM_WORDS  = 512;
  localparam int PROG_WORDS = 3072;
  localparam int XMEM_WORDS = 1024;
  localparam int YMEM_WORDS = 1024;
  localparam logic [11:0] PROG_LAST = 12'(PROG_WORDS - 1);
  localparam logic [11:0] X_LAST    = 12'(XMEM_WORDS - 1);
  localparam logic [11:0] Y_LAST    = 12'(YMEM_WORDS - 1);
  localparam logic [1:0]  REGION_PROG = 2'h0;
  localparam logic [1:0]  REGION_X    = 2'h1;
  localparam logic [1:0]  REGION_Y    = 2'h2;

  // ---------------------------------------------------------------
  // modes, {strap a, strap b}
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_SPI_M = 2'h0;
  localparam logic [1:0] MODE_DEBUG = 2'h1;
  localparam logic [1:0] MODE_I2C_M = 2'h2;
  localparam logic [1:0] MODE_I2C_S = 2'h3;

  // ---------------------------------------------------------------
  // serial memory protocol
  // ---------------------------------------------------------------
  localparam logic [7:0] SPI_READ_CMD  = 8'h03;
  localparam logic [1:0] SPI_HDR_BYTES = 2'h3;  // command + 2 address
  localparam logic [6:0] I2C_MEM_ADDR  = 7'h50;
  localparam logic [6:0] I2C_OWN_ADDR  = 7'h2a; // arbitrary value

  typedef enum logic [1:0] {T_IDLE, T_LOAD, T_DEBUG, T_DONE} blpl_top_t;
  typedef enum logic [2:0] {
    IM_START, IM_ADDR, IM_READ, IM_STOP, IM_END
  } blpl_im_t;

endpackage : blpl_pkg

// File: verification/blpl_boot_loader_bench.sv
// blpl_boot_loader_bench: self-checking bench of the boot loader
// assumes blpl_pkg compiled; spi partner in blpl_spi_mem
`timescale 1ns/1ps
module blpl_boot_loader_bench;
  import blpl_pkg::*;
  logic        clk, rst, stra, strb, bscl, bsda;
  logic [8:0]  rom_addr;
  logic [23:0] rom_data, mem_data, hdr_q;
  logic [11:0] mem_addr;
  logic        core_boot, app_run, debug_en, sck, ss_n, mosi, miso;
  logic        scl_out, scl_oe, sda_out, sda_oe, p_we, x_we, y_we;
  wire         scl = bscl & !scl_oe;
  wire         sda = bsda & !sda_oe;
  int          failures, check_count;
  logic [23:0] got_word;
  int          got_cnt = 0;

  // distinct words at both ends so an address slip shows
  localparam logic [23:0] ROM_W0  = 24'h1a2b3c;
  localparam logic [23:0] ROM_W1  = 24'hc3b2a1;
  localparam logic [23:0] ROM_WX  = 24'h3c5a96;
  localparam logic [23:0] I2C_WRD = 24'ha55ac3;

  blpl_boot_loader #(.BOOT_ROM('{0: ROM_W0, 511: ROM_W1,
                                 default: ROM_WX})) i_blpl_boot_loader (
    .clk(clk), .rst(rst), .i2c_link_clk(scl), .boot_strap_pin_a(stra),
    .boot_strap_pin_b(strb), .rom_addr(rom_addr), .rom_data(rom_data),
    .core_boot(core_boot), .app_run(app_run), .debug_en(debug_en),
    .spi_sck(sck), .spi_ss_n(ss_n), .spi_mosi(mosi), .spi_miso(miso),
    .i2c_scl_in(scl), .i2c_scl_out(scl_out), .i2c_scl_oe(scl_oe),
    .i2c_sda_in(sda), .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe),
    .program_memory_move_we(p_we), .x_data_memory_we(x_we),
    .y_data_memory_we(y_we), .mem_addr(mem_addr), .mem_data(mem_data));
  blpl_spi_mem i_blpl_spi_mem (.sck(sck), .ss_n(ss_n), .mosi(mosi),
    .miso(miso), .hdr_q(hdr_q));

  // program writes seen mid-frame, where no task can wait on them
  always @(negedge clk) if (p_we) begin
    got_word = mem_data;
    got_cnt++;
  end

  // ---------------------------------------------------------------
  // common tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // straps held steady over the whole reset
  task automatic boot(input logic a, b);
    @(negedge clk);
    {stra, strb, rst} = {a, b, 1'b1};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask : boot

  task automatic wait_sig(ref logic s, input int lim, output bit ok);
    ok = 0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge clk);
      ok = (s === 1'b1);
    end
  endtask : wait_sig

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  function automatic logic [7:0] pat(input int k);
    return 8'(k * 7 + 1);
  endfunction : pat

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_rom();
    rom_addr = 9'h1ff;
    tick(1);
    chk("rom_last", ROM_W1, rom_data);
    rom_addr = 9'h000;
    tick(1);
    chk("rom_first", ROM_W0, rom_data);
    rom_addr = 9'h0aa;
    tick(1);
    chk("rom_mid", ROM_WX, rom_data);
  endtask : t_rom

  task automatic t_debug();
    bit ok;
    boot(1'b0, 1'b1);
    chk("debug_en", 1'b1, debug_en);
    wait_sig(p_we, 400, ok);
    chk("debug_no_load", 1'b0, ok);
    chk("debug_ss_n", 1'b1, ss_n);
    chk("debug_boot", 1'b1, core_boot);
  endtask : t_debug

  task automatic t_spi();
    bit ok;
    boot(1'b0, 1'b0);
    chk("spi_ss_n", 1'b0, ss_n);
    chk("spi_debug", 1'b0, debug_en);
    for (int n = 0; n < 4; n++) begin
      wait_sig(p_we, 3000, ok);
      chk("prog_we", 1'b1, ok);
      chk("prog_addr", 24'(n), 24'(mem_addr));
      chk("prog_data", {pat(3*n), pat(3*n+1), pat(3*n+2)}, mem_data);
      chk("x_we", 1'b0, x_we);
    end
    chk("spi_header", 24'h030000, hdr_q);
    chk("spi_boot", 1'b1, core_boot);
    chk("spi_app", 1'b0, app_run);
  endtask : t_spi

  task automatic t_i2c_m();
    bit ok;
    boot(1'b1, 1'b0);
    wait_sig(sda_oe, 400, ok);
    chk("im_start", 1'b1, ok);
    chk("im_scl_high", 1'b0, scl_oe);
    wait_sig(scl_oe, 400, ok);
    chk("im_scl", 1'b1, ok);
    chk("im_ss_n", 1'b1, ss_n);
    chk("im_scl_out", 1'b0, scl_out);
    chk("im_sda_out", 1'b0, sda_out);
  endtask : t_i2c_m

  // slow scl: the slave samples on the core clock as well
  task automatic i2c_bit(input logic b);
    bsda = b;
    tick(5);
    bscl = 1'b1;
    tick(10);
    bscl = 1'b0;
    tick(5);
  endtask : i2c_bit

  task automatic i2c_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(v[i]);
    bsda = 1'b1;
    tick(5);
    bscl = 1'b1;
    tick(5);
    ack = (sda === 1'b0);
    tick(5);
    bscl = 1'b0;
    tick(5);
  endtask : i2c_byte

  // address byte, then one full word as three data bytes
  task automatic i2c_frame(input logic [7:0] b0, output logic a0,
                           output int na);
    logic a;
    na = 0;
    {bsda, bscl} = 2'b11;
    tick(8);
    bsda = 1'b0;
    tick(8);
    bscl = 1'b0;
    tick(8);
    i2c_byte(b0, a0);
    for (int i = 0; i < 3; i++) begin
      i2c_byte(I2C_WRD[23-8*i -: 8], a);
      if (a === 1'b1) na++;
    end
    bsda = 1'b0;
    tick(5);
    bscl = 1'b1;
    tick(8);
    bsda = 1'b1;
    tick(8);
  endtask : i2c_frame

  task automatic t_i2c_s();
    logic a0;
    int   na;
    int   w0;
    boot(1'b1, 1'b1);
    w0 = got_cnt;
    i2c_frame({I2C_OWN_ADDR ^ 7'h01, 1'b0}, a0, na);
    chk("is_wrong_addr", 1'b0, a0);
    chk("is_wrong_data", 24'h000000, 24'(na));
    chk("is_wrong_word", 24'h000000, 24'(got_cnt - w0));
    i2c_frame({I2C_OWN_ADDR, 1'b0}, a0, na);
    chk("is_own_addr", 1'b1, a0);
    chk("is_data_ack", 24'h000003, 24'(na));
    chk("is_word_cnt", 24'h000001, 24'(got_cnt - w0));
    chk("is_word", I2C_WRD, got_word);
    chk("is_scl_oe", 1'b0, scl_oe);
  endtask : t_i2c_s

  // ---------------------------------------------------------------
  // clock, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {rst, stra, strb, bscl, bsda} = 5'b10011;
    rom_addr = 9'h000;
    failures = 0;
    check_count = 0;
    t_rom();
    t_debug();
    t_spi();
    t_i2c_m();
    t_i2c_s();
    conclude();
  end

  // whole run is near 3700 core cycles
  initial begin
    #2000000;
    failures++;
    conclude();
  end
endmodule : blpl_boot_loader_bench

// File: verification/blpl_spi_mem.sv
// blpl_spi_mem: behavioural serial memory on the far side of the spi boot
// assumes spi mode 0, msb first; a read command plus two address bytes
`timescale 1ns/1ps
module blpl_spi_mem (
  input  wire logic        sck,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic [23:0]      hdr_q
);
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  int         bit_cnt;
  int         byte_cnt;

  // data byte k of the stream; the bench knows the same pattern
  function automatic logic [7:0] pat(input int k);
    return 8'(k * 7 + 1);
  endfunction : pat

  initial begin
    miso = 1'b0;
    hdr_q = 24'h000000;
    bit_cnt = 0;
    byte_cnt = 0;
    tx_sh = 8'h00;
  end

  // ---------------------------------------------------------------
  // shifting
  // ---------------------------------------------------------------
  always @(negedge ss_n) begin
    bit_cnt = 0;
    byte_cnt = 0;
  end

  // eight in while eight out, both on sck edges
  always @(posedge sck) if (!ss_n) begin
    rx_sh = {rx_sh[6:0], mosi};
    bit_cnt++;
    if (bit_cnt == 8) begin
      if (byte_cnt < 3) hdr_q = {hdr_q[15:0], rx_sh};
      byte_cnt++;
      bit_cnt = 0;
    end
  end

  always @(negedge sck) if (!ss_n) begin
    if (bit_cnt == 0) tx_sh = pat(byte_cnt - 3);
    else tx_sh = {tx_sh[6:0], 1'b0};
    miso = tx_sh[7];
  end

  // deselected: line is not held, so never show the last bit
  always @(posedge ss_n) miso = ~miso;
endmodule : blpl_spi_mem
